/* File: logic/baie_pkg.sv */
// shared constants for the branch and increment execution block
// assumes one core instruction clock, synchronous active-high reset
package baie_pkg;
    localparam int INSTR_W   = 12;
    localparam int DATA_W    = 8;
    localparam int PC_W      = 11;
    localparam int FADDR_W   = 5;
    localparam int LIT_W     = 9;
    // opcode patterns and the instruction bits they compare against
    localparam logic [2:0] JUMP_PATTERN     = 3'h5;
    localparam int         JUMP_TOP         = 11;
    localparam int         JUMP_BOT         = 9;
    localparam logic [5:0] INC_PATTERN      = 6'h0a;
    localparam logic [5:0] INC_SKIP_PATTERN = 6'h0f;
    localparam int         OP6_TOP          = 11;
    localparam int         OP6_BOT          = 6;
    localparam int         DEST_BIT         = 5;
    // status page bits copied into the upper counter bits
    localparam int         PAGE_TOP         = 6;
    localparam int         PAGE_BOT         = 5;
    localparam int         PC_PAGE_BOT      = 9;
    localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;
    localparam logic [FADDR_W-1:0] FADDR_RESET = 5'h00;
    typedef enum logic [1:0] {
        BAIE_OP_NONE,
        BAIE_OP_JUMP,
        BAIE_OP_INC,
        BAIE_OP_INC_SKIP
    } baie_op_t;
    typedef enum logic {
        BAIE_RUN,
        BAIE_FLUSH
    } baie_state_t;
endpackage

/* File: logic/baie_decode.sv */
// opcode classifier for the jump and the two increment instructions
// assumes a full 12-bit instruction word, pure combinational
module baie_decode
    import baie_pkg::*;
(
    input  wire logic [INSTR_W-1:0] i_instr,
    output baie_op_t                o_op,
    output logic                    o_dest_reg,
    output logic [FADDR_W-1:0]      o_faddr,
    output logic [LIT_W-1:0]        o_literal
);
    function automatic baie_op_t classify(input logic [INSTR_W-1:0] w);
        if (w[JUMP_TOP:JUMP_BOT] == JUMP_PATTERN) begin
            return BAIE_OP_JUMP;
        end else if (w[OP6_TOP:OP6_BOT] == INC_PATTERN) begin
            return BAIE_OP_INC;
        end else if (w[OP6_TOP:OP6_BOT] == INC_SKIP_PATTERN) begin
            return BAIE_OP_INC_SKIP;
        end else begin
            return BAIE_OP_NONE;
        end
    endfunction

    always_comb begin
        o_op       = classify(i_instr);
        o_dest_reg = i_instr[DEST_BIT];
        o_faddr    = i_instr[FADDR_W-1:0];
        o_literal  = i_instr[LIT_W-1:0];
    end
endmodule

/* File: logic/baie_exec.sv */
// execute stage for jump, increment and increment-skip instructions
// assumes fetch supplies a word with a valid strobe each cycle and the
// register file returns the addressed byte combinationally on i_fdata
import baie_pkg::*;

module baie_exec
    import baie_pkg::*;
(
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    input  wire logic               i_ce,
    input  wire logic               i_valid,
    input  wire logic [INSTR_W-1:0] i_instr,
    input  wire logic [DATA_W-1:0]  i_fdata,
    input  wire logic [DATA_W-1:0]  i_status,
    output logic                    o_f_we,
    output logic [FADDR_W-1:0]      o_f_addr,
    output logic [DATA_W-1:0]       o_f_wdata,
    output logic                    o_w_we,
    output logic [DATA_W-1:0]       o_w_wdata,
    output logic                    o_zero_we,
    output logic                    o_zero,
    output logic                    o_pc_load,
    output logic [PC_W-1:0]         o_pc_target,
    output logic                    o_flush,
    output logic                    o_idle_cycle
);
    baie_op_t              op;
    logic                  dest_reg;
    logic [FADDR_W-1:0]    faddr;
    logic [LIT_W-1:0]      literal;
    logic [DATA_W-1:0]     sum;
    logic                  live;

    baie_state_t           state;
    baie_state_t           next_state;
    logic                  f_we;
    logic                  next_f_we;
    logic [FADDR_W-1:0]    f_addr;
    logic [FADDR_W-1:0]    next_f_addr;
    logic [DATA_W-1:0]     f_wdata;
    logic [DATA_W-1:0]     next_f_wdata;
    logic                  w_we;
    logic                  next_w_we;
    logic [DATA_W-1:0]     w_wdata;
    logic [DATA_W-1:0]     next_w_wdata;
    logic                  zero_we;
    logic                  next_zero_we;
    logic                  zero;
    logic                  next_zero;
    logic                  pc_load;
    logic                  next_pc_load;
    logic [PC_W-1:0]       pc_target;
    logic [PC_W-1:0]       next_pc_target;
    logic                  flush;
    logic                  next_flush;
    logic                  idle;
    logic                  next_idle;

    baie_decode u_decode (
        .i_instr    (i_instr),
        .o_op       (op),
        .o_dest_reg (dest_reg),
        .o_faddr    (faddr),
        .o_literal  (literal)
    );

    // the word arriving in the cycle after a jump or skip is the stale
    // prefetch, so the flush state swallows it instead of decoding
    assign live = i_valid && (state == BAIE_RUN);
    assign sum  = i_fdata + DATA_ONE;

    always_comb begin
        next_state     = BAIE_RUN;
        next_f_we      = 1'b0;
        next_f_addr    = f_addr;
        next_f_wdata   = f_wdata;
        next_w_we      = 1'b0;
        next_w_wdata   = w_wdata;
        next_zero_we   = 1'b0;
        next_zero      = zero;
        next_pc_load   = 1'b0;
        next_pc_target = pc_target;
        next_flush     = 1'b0;
        next_idle      = 1'b0;
        case (state)
            BAIE_RUN: begin
                if (live) begin
                    case (op)
                        BAIE_OP_JUMP: begin
                            next_pc_target = {i_status[PAGE_TOP:PAGE_BOT],
                                              literal};
                            next_pc_load   = 1'b1;
                            next_flush     = 1'b1;
                            next_state     = BAIE_FLUSH;
                        end
                        BAIE_OP_INC, BAIE_OP_INC_SKIP: begin
                            next_f_addr  = faddr;
                            next_f_wdata = sum;
                            next_w_wdata = sum;
                            next_f_we    = dest_reg;
                            next_w_we    = !dest_reg;
                            if (op == BAIE_OP_INC) begin
                                next_zero_we = 1'b1;
                                next_zero    = (sum == DATA_ZERO);
                            end else if (sum == DATA_ZERO) begin
                                next_flush = 1'b1;
                                next_state = BAIE_FLUSH;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            BAIE_FLUSH: begin
                next_idle  = 1'b1;
                next_state = BAIE_RUN;
            end
            default: begin
                next_state = BAIE_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state     <= BAIE_RUN;
            f_we      <= 1'b0;
            f_addr    <= FADDR_RESET;
            f_wdata   <= DATA_ZERO;
            w_we      <= 1'b0;
            w_wdata   <= DATA_ZERO;
            zero_we   <= 1'b0;
            zero      <= 1'b0;
            pc_load   <= 1'b0;
            pc_target <= PC_RESET;
            flush     <= 1'b0;
            idle      <= 1'b0;
        end else if (i_ce) begin
            state     <= next_state;
            f_we      <= next_f_we;
            f_addr    <= next_f_addr;
            f_wdata   <= next_f_wdata;
            w_we      <= next_w_we;
            w_wdata   <= next_w_wdata;
            zero_we   <= next_zero_we;
            zero      <= next_zero;
            pc_load   <= next_pc_load;
            pc_target <= next_pc_target;
            flush     <= next_flush;
            idle      <= next_idle;
        end
    end

    assign o_f_we       = f_we;
    assign o_f_addr     = f_addr;
    assign o_f_wdata    = f_wdata;
    assign o_w_we       = w_we;
    assign o_w_wdata    = w_wdata;
    assign o_zero_we    = zero_we;
    assign o_zero       = zero;
    assign o_pc_load    = pc_load;
    assign o_pc_target  = pc_target;
    assign o_flush      = flush;
    assign o_idle_cycle = idle;

    property p_jump_target;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && live && op == BAIE_OP_JUMP) |=>
            pc_load && pc_target == {$past(i_status[PAGE_TOP:PAGE_BOT]),
                                     $past(i_instr[LIT_W-1:0])};
    endproperty
    a_jump_target: assert property (p_jump_target)
        else $error("jump target wrong");

    property p_jump_no_flags;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && live && op == BAIE_OP_JUMP) |=> !zero_we && !f_we && !w_we;
    endproperty
    a_jump_no_flags: assert property (p_jump_no_flags)
        else $error("jump touched state");

    property p_jump_two_cycles;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && live && op == BAIE_OP_JUMP) ##1 i_ce |=> idle;
    endproperty
    a_jump_two_cycles: assert property (p_jump_two_cycles)
        else $error("jump not two cycles");

    property p_page_bits;
        @(posedge i_clock) disable iff (i_rst)
        pc_load |-> pc_target[PC_W-1:PC_PAGE_BOT] ==
                    $past(i_status[PAGE_TOP:PAGE_BOT]);
    endproperty
    a_page_bits: assert property (p_page_bits)
        else $error("page bits wrong");

    property p_inc_zero;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && live && op == BAIE_OP_INC) |=>
            zero_we && (zero == (w_wdata == DATA_ZERO)) && !flush;
    endproperty
    a_inc_zero: assert property (p_inc_zero)
        else $error("increment zero flag wrong");

    property p_dest;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && live && (op == BAIE_OP_INC || op == BAIE_OP_INC_SKIP)) |=>
            (f_we == $past(i_instr[DEST_BIT])) && (w_we != f_we)
            && f_wdata == $past(i_fdata) + DATA_ONE;
    endproperty
    a_dest: assert property (p_dest)
        else $error("destination wrong");

    property p_skip;
        @(posedge i_clock) disable iff (i_rst)
        (i_ce && live && op == BAIE_OP_INC_SKIP) |=>
            !zero_we && (flush == (f_wdata == DATA_ZERO));
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip decision wrong");

    property p_skip_idle;
        @(posedge i_clock) disable iff (i_rst)
        (flush && !pc_load && i_ce) |=> idle && !f_we && !w_we;
    endproperty
    a_skip_idle: assert property (p_skip_idle)
        else $error("skip lacks idle cycle");

    property p_discard;
        @(posedge i_clock) disable iff (i_rst)
        (state == BAIE_FLUSH && i_ce) |=> !f_we && !w_we && !pc_load;
    endproperty
    a_discard: assert property (p_discard)
        else $error("discarded word executed");
endmodule

/* File: test/baie_regfile_model.sv */
// far-side model: file register array seen by the execute stage
// assumes reads are combinational on the addressed word, writes land on
// the next rising edge; the bench may preload entries directly
module baie_regfile_model
    import baie_pkg::*;
(
    input  wire logic               i_clock,
    input  wire logic [INSTR_W-1:0] i_instr,
    input  wire logic               i_f_we,
    input  wire logic [FADDR_W-1:0] i_f_addr,
    input  wire logic [DATA_W-1:0]  i_f_wdata,
    output logic [DATA_W-1:0]       o_fdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] regs [32];

    initial begin
        for (int a = 0; a < 32; a++) begin
            regs[a] = DATA_ZERO;
        end
    end

    assign o_fdata = regs[i_instr[FADDR_W-1:0]];

    always @(posedge i_clock) begin
        if (i_f_we) begin
            regs[i_f_addr] <= i_f_wdata;
        end
    end
endmodule

/* File: test/test_branch_and_increment_exec.sv */
// self-checking bench for the jump and increment execute stage
// assumes one 25 MHz clock, occasional clock-enable stalls, random
// instruction mix
module test_branch_and_increment_exec
    import baie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic f_we, w_we, z_we, zero, pc, flush, idle;
        logic [DATA_W-1:0]  data;
        logic [FADDR_W-1:0] addr;
        logic [PC_W-1:0]    tgt;
    } baie_note_t;

    logic               i_clock, i_rst, i_ce, i_valid;
    logic [INSTR_W-1:0] i_instr;
    logic [DATA_W-1:0]  i_fdata, i_status;
    logic               o_f_we, o_w_we, o_zero_we, o_zero;
    logic               o_pc_load, o_flush, o_idle_cycle;
    logic [FADDR_W-1:0] o_f_addr;
    logic [DATA_W-1:0]  o_f_wdata, o_w_wdata;
    logic [PC_W-1:0]    o_pc_target;
    integer             mismatches, checks, seed;
    baie_note_t         q[$];
    baie_note_t         got;
    logic               drop_next;
    // enable seen at the last edge: a frozen edge repeats old pulses
    logic               ce_q;

    baie_exec u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
        .i_valid(i_valid), .i_instr(i_instr), .i_fdata(i_fdata),
        .i_status(i_status), .o_f_we(o_f_we), .o_f_addr(o_f_addr),
        .o_f_wdata(o_f_wdata), .o_w_we(o_w_we), .o_w_wdata(o_w_wdata),
        .o_zero_we(o_zero_we), .o_zero(o_zero), .o_pc_load(o_pc_load),
        .o_pc_target(o_pc_target), .o_flush(o_flush),
        .o_idle_cycle(o_idle_cycle));

    baie_regfile_model m (.i_clock(i_clock), .i_instr(i_instr),
        .i_f_we(o_f_we), .i_f_addr(o_f_addr), .i_f_wdata(o_f_wdata),
        .o_fdata(i_fdata));

    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    task summarize;
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task fail(input string msg);
        mismatches++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    // one cycle of fetch; expectation built from what the model presents
    task step(input logic v, input logic [INSTR_W-1:0] w);
        baie_note_t n, idle;
        logic [DATA_W-1:0] r;
        logic nd;
        @(posedge i_clock);
        if (($random(seed) & 15) == 0) begin
            #1 i_ce = 1'b0;
            @(posedge i_clock);
        end
        #1;
        i_ce = 1'b1;
        i_valid = v;
        i_instr = w;
        i_status = DATA_W'($random(seed));
        if (($random(seed) & 3) == 0) m.regs[w[4:0]] = 8'hff;
        else m.regs[w[4:0]] = DATA_W'($random(seed));
        #1;
        n = '0;
        idle = '0;
        idle.idle = 1'b1;
        nd = 1'b0;
        r = i_fdata + DATA_ONE;
        if (v && !drop_next) begin
            if (w[JUMP_TOP:JUMP_BOT] == JUMP_PATTERN) begin
                n.pc = 1'b1;
                n.flush = 1'b1;
                n.tgt = {i_status[PAGE_TOP:PAGE_BOT], w[LIT_W-1:0]};
                nd = 1'b1;
            end else if (w[OP6_TOP:OP6_BOT] == INC_PATTERN ||
                         w[OP6_TOP:OP6_BOT] == INC_SKIP_PATTERN) begin
                n.f_we = w[DEST_BIT];
                n.w_we = !w[DEST_BIT];
                n.data = r;
                n.addr = w[FADDR_W-1:0];
                if (w[OP6_TOP:OP6_BOT] == INC_PATTERN) begin
                    n.z_we = 1'b1;
                    n.zero = (r == DATA_ZERO);
                end else if (r == DATA_ZERO) begin
                    n.flush = 1'b1;
                    nd = 1'b1;
                end
            end
            if (n != '0) q.push_back(n);
            if (nd) q.push_back(idle);
        end
        drop_next = nd;
    endtask

    always @(posedge i_clock) begin
        ce_q <= i_ce;
    end

    always @(negedge i_clock) begin
        if (!i_rst && ce_q && (o_f_we | o_w_we | o_zero_we | o_pc_load
                       | o_flush | o_idle_cycle)) begin
            if (q.size() == 0) begin
                checks++;
                fail("output with nothing pending");
            end else begin
                got = q.pop_front();
                checks++;
                if ({o_f_we, o_w_we, o_zero_we, o_pc_load, o_flush,
                     o_idle_cycle} !== {got.f_we, got.w_we, got.z_we,
                     got.pc, got.flush, got.idle})
                    fail("pulse set");
                if (got.f_we && (o_f_addr !== got.addr ||
                    o_f_wdata !== got.data)) fail("file write");
                if (got.w_we && o_w_wdata !== got.data)
                    fail("accumulator write");
                if (got.z_we && o_zero !== got.zero)
                    fail("zero flag");
                if (got.pc && o_pc_target !== got.tgt)
                    fail("jump target");
            end
        end
    end

    initial begin
        #100000;
        mismatches++;
        summarize();
    end

    initial begin
        logic [INSTR_W-1:0] w;
        int                 kind;
        seed = 88;
        mismatches = 0;
        checks = 0;
        i_rst = 1'b1;
        i_ce = 1'b1;
        i_valid = 1'b0;
        i_instr = '0;
        i_status = '0;
        drop_next = 1'b0;
        repeat (4) @(posedge i_clock);
        #1 i_rst = 1'b0;
        step(1'b1, 12'hbff);
        step(1'b1, 12'h2bf);
        for (int k = 0; k < 600; k++) begin
            kind = $random(seed) & 3;
            w = INSTR_W'($random(seed));
            case (kind)
                0: w[JUMP_TOP:JUMP_BOT] = JUMP_PATTERN;
                1: w[OP6_TOP:OP6_BOT] = INC_PATTERN;
                2: w[OP6_TOP:OP6_BOT] = INC_SKIP_PATTERN;
                default: begin
                    while (w[JUMP_TOP:JUMP_BOT] == JUMP_PATTERN ||
                           w[OP6_TOP:OP6_BOT] == INC_PATTERN ||
                           w[OP6_TOP:OP6_BOT] == INC_SKIP_PATTERN) begin
                        w = INSTR_W'($random(seed));
                    end
                end
            endcase
            step(($random(seed) & 7) != 0, w);
        end
        repeat (3) step(1'b0, '0);
        checks++;
        if (q.size() != 0) fail("expected output never came");
        summarize();
    end
endmodule
